// *** rtl/rfd_regs.svh ***
// register offsets, field positions and reset values of the receive fifo
// assumes word-aligned ahb-lite accesses, offsets are byte addresses
`ifndef RFD_REGS_SVH
`define RFD_REGS_SVH
`define RFD_OFS_CTRL 8'h00
`define RFD_OFS_PINCFG 8'h04
`define RFD_OFS_TIMING 8'h08
`define RFD_OFS_STATUS 8'h0c
`define RFD_OFS_FIFO_DATA 8'h10
`define RFD_OFS_FIFO_STAT 8'h14
`define RFD_CTRL_LOCK 0
`define RFD_CTRL_INIT_CYC 1
`define RFD_CTRL_INIT_FRM 2
`define RFD_CTRL_EXT8 3
`define RFD_CTRL_MODE 4
`define RFD_CTRL_RST 32'h0000_0000
`define RFD_PIN_POL 12
`define RFD_PIN_RST 32'h0000_0b1a
`define RFD_TIM_CHIP 16
`define RFD_TIM_RST 32'h0008_0010
`define RFD_FIFO_BITS 256
`define RFD_XFER_BITS 6'd32
`define RFD_BIT_DLY_SH 4
`define RFD_CHIP_DLY_SH 3
`endif

// *** rtl/rfd_pkg.sv ***
// types shared by the receive fifo and its bench
// assumes the constants header is included by the users that need offsets
package rfd_pkg;
  typedef enum logic [2:0] {
    RFD_POF = 3'b000,
    RFD_POTP = 3'b001,
    RFD_CHIP_DATA_MODE = 3'b010,
    RFD_MATCHED_FILTER_MODE = 3'b011,
    RFD_RAW_SLICER_MODE = 3'b100
  } rfd_mode_e;
  typedef enum logic [2:0] {
    RFD_SEL_LOW = 3'b000,
    RFD_SEL_HIGH = 3'b001,
    RFD_SEL_PAY_DATA = 3'b010,
    RFD_SEL_PAY_STR = 3'b011,
    RFD_SEL_CHIP_DATA = 3'b100,
    RFD_SEL_CHIP_STR = 3'b101,
    RFD_SEL_MF = 3'b110,
    RFD_SEL_RAW = 3'b111
  } rfd_sel_e;
  // demodulator side, all asynchronous to CLK_I
  typedef struct packed {
    logic dclk;
    logic data;
    logic telegram_start_pattern;
    logic tsi_sel;
    logic end_of_message;
    logic sync_loss;
    logic chip;
    logic chip_clk;
    logic mf;
    logic raw;
  } rfd_demod_s;
endpackage

// *** rtl/rfd_rx_fifo.sv ***
// receive fifo, status word, lock handling and data output pin routing
// assumes one ahb-lite master, demodulator signals asynchronous to CLK_I
`timescale 1ns/1ps
`default_nettype none
`include "rfd_regs.svh"
// Function
// - inactive receiver drives data outputs low
// - payload strobe at bit/16, lasts bit/2
// - software inverts pin polarity
// - chip strobe at chip/8, lasts chip/2
// - chip stream and chip strobe onto pins
// - two-chip filter sign onto pin
// - one-chip filter result onto pin
// - fifo holds 256 bits, packet modes
// - extended start writes pattern bit first
// - start pattern opens write, clock advances
// - read pointer advances per read bit
// - pointers wrap from 255 to zero
// - writing stops at message end, sync loss
// - lock at message end blocks new data
// - lock halts the receive chain
// - lock released by readout, clear, cycle init
// - status word carries valid bit count
// - overtaking writer sets overflow flag
// - start after overflow clears and inits
// - only decoded payload and the extended-start pattern bit stored
// - frame start inits fifo unless locked
module rfd_rx_fifo
  import rfd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire rfd_pkg::rfd_demod_s DEMOD_I,
  input wire logic RX_ACTIVE_I,
  input wire logic RUN_SLAVE_I,
  input wire logic SP_TO_RUN_I,
  output logic [3:0] PIN_O,
  output logic RX_HALT_O
);
  import rfd_pkg::*;

  localparam int FB = `RFD_FIFO_BITS;

  // ==========================================================
  // input synchronisers
  rfd_demod_s sync1_ff;
  rfd_demod_s sync2_ff;
  rfd_demod_s prev_ff;
  logic act1_ff;
  logic act2_ff;

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
      act1_ff <= 1'b0;
      act2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= DEMOD_I;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
      act1_ff <= RX_ACTIVE_I;
      act2_ff <= act1_ff;
    end
  end

  logic dclk_rise;
  logic chip_rise;
  logic tsi_rise;
  logic eom_rise;
  logic sl_rise;
  assign dclk_rise = sync2_ff.dclk & ~prev_ff.dclk;
  assign chip_rise = sync2_ff.chip_clk & ~prev_ff.chip_clk;
  assign tsi_rise = sync2_ff.telegram_start_pattern & ~prev_ff.telegram_start_pattern;
  assign eom_rise = sync2_ff.end_of_message & ~prev_ff.end_of_message;
  assign sl_rise = sync2_ff.sync_loss & ~prev_ff.sync_loss;

  // ==========================================================
  // control registers
  logic [31:0] ctrl_ff;
  logic [31:0] pincfg_ff;
  logic [31:0] timing_ff;
  logic lock_en;
  logic init_cyc_en;
  logic init_frm_en;
  logic ext8_en;
  rfd_mode_e mode;
  logic [15:0] bit_per;
  logic [15:0] chip_per;
  assign lock_en = ctrl_ff[`RFD_CTRL_LOCK];
  assign init_cyc_en = ctrl_ff[`RFD_CTRL_INIT_CYC];
  assign init_frm_en = ctrl_ff[`RFD_CTRL_INIT_FRM];
  assign ext8_en = ctrl_ff[`RFD_CTRL_EXT8];
  assign mode = rfd_mode_e'(ctrl_ff[`RFD_CTRL_MODE +: 3]);
  assign bit_per = timing_ff[15:0];
  assign chip_per = timing_ff[`RFD_TIM_CHIP +: 16];

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic acc_ok;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  assign acc_ok = HSEL_I & HREADY_I & HTRANS_I[1];

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= acc_ok & HWRITE_I;
      wr_addr_ff <= HADDR_I[7:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ctrl_ff <= `RFD_CTRL_RST;
      pincfg_ff <= `RFD_PIN_RST;
      timing_ff <= `RFD_TIM_RST;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == `RFD_OFS_CTRL)
        ctrl_ff <= {25'h0, HWDATA_I[6:0]};
      if (wr_addr_ff == `RFD_OFS_PINCFG)
        pincfg_ff <= {16'h0, HWDATA_I[15:0]};
      if (wr_addr_ff == `RFD_OFS_TIMING)
        timing_ff <= HWDATA_I;
    end
  end

  // ==========================================================
  // fifo storage and pointers
  logic [FB-1:0] mem_ff;
  logic [7:0] wr_ptr_ff;
  logic [7:0] rd_ptr_ff;
  logic [8:0] cnt_ff;
  logic ovf_ff;
  logic locked_ff;
  logic writing_ff;
  logic [7:0] stat_ff;

  logic rd_pop;
  logic [5:0] rd_n;
  logic [31:0] rd_word;
  logic tsi_ok;
  logic pkt_mode;
  logic frm_init;
  logic cyc_init;
  logic fifo_init;
  logic wr_en;
  logic wr_bit;
  logic [8:0] cnt_nxt;

  // a read pops what is there, at most one transfer worth
  assign rd_pop = acc_ok & ~HWRITE_I & (HADDR_I[7:0] == `RFD_OFS_FIFO_DATA);
  assign rd_n = (cnt_ff >= 9'(`RFD_XFER_BITS)) ? `RFD_XFER_BITS : cnt_ff[5:0];

  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_rd
      // bit 0 is the oldest bit, read-pointer order
      assign rd_word[g] = (6'(g) < rd_n) ? mem_ff[rd_ptr_ff + 8'(g)] : 1'b0;
    end
  endgenerate

  // while locked no new telegram is accepted
  assign tsi_ok = tsi_rise & ~locked_ff;
  // fifo only fed in packet modes
  assign pkt_mode = (mode == RFD_POF) | (mode == RFD_POTP);
  assign frm_init = tsi_ok & (ovf_ff | init_frm_en);
  assign cyc_init = init_cyc_en & (RUN_SLAVE_I | SP_TO_RUN_I);
  assign fifo_init = frm_init | cyc_init;
  // the pattern bit goes in ahead of the payload
  assign wr_bit = tsi_ok ? sync2_ff.tsi_sel : sync2_ff.data;
  // demod data clock only counts between start and stop
  assign wr_en = pkt_mode & ~locked_ff &
                 ((tsi_ok & ext8_en) | (writing_ff & ~tsi_ok & dclk_rise));

  always_comb
  begin
    cnt_nxt = fifo_init ? 9'h000 : cnt_ff - (rd_pop ? 9'(rd_n) : 9'h000);
    if (wr_en && cnt_nxt != 9'(FB))
      cnt_nxt = cnt_nxt + 9'h001;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      mem_ff <= '0;
    else if (wr_en)
      mem_ff[fifo_init ? 8'h00 : wr_ptr_ff] <= wr_bit;
  end

  // 8-bit pointers wrap from 255 to zero by themselves
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      wr_ptr_ff <= 8'h00;
      rd_ptr_ff <= 8'h00;
      cnt_ff <= 9'h000;
    end
    else
    begin
      if (fifo_init)
        wr_ptr_ff <= wr_en ? 8'h01 : 8'h00;
      else if (wr_en)
        wr_ptr_ff <= wr_ptr_ff + 8'h01;
      if (fifo_init)
        rd_ptr_ff <= 8'h00;
      else if (rd_pop)
        rd_ptr_ff <= rd_ptr_ff + 8'(rd_n);
      cnt_ff <= cnt_nxt;
    end
  end

  // writer overtaking the reader; the init clear wins over the set
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      ovf_ff <= 1'b0;
    else if (wr_en && !fifo_init && cnt_ff == 9'(FB) && !rd_pop)
      ovf_ff <= 1'b1;
    else if (fifo_init)
      ovf_ff <= 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      writing_ff <= 1'b0;
    else if (tsi_ok && pkt_mode)
      writing_ff <= 1'b1;
    else if (eom_rise || sl_rise || locked_ff)
      writing_ff <= 1'b0;
  end

  // lock set wins over release in the same cycle
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      locked_ff <= 1'b0;
    else if (eom_rise && lock_en && writing_ff)
      locked_ff <= 1'b1;
    else if (!lock_en || cyc_init || (rd_pop && cnt_nxt == 9'h000))
      locked_ff <= 1'b0;
  end

  // status word of the last transfer, S6 reads zero
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      stat_ff <= 8'h00;
    else if (rd_pop)
      stat_ff <= {ovf_ff, 1'b0, rd_n};
  end

  // ==========================================================
  // read data, registered at the address phase
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;

  always_comb
  begin
    unique case (HADDR_I[7:0])
      `RFD_OFS_CTRL: rd_mux = ctrl_ff;
      `RFD_OFS_PINCFG: rd_mux = pincfg_ff;
      `RFD_OFS_TIMING: rd_mux = timing_ff;
      `RFD_OFS_STATUS: rd_mux = {20'h0, writing_ff, locked_ff, ovf_ff, cnt_ff};
      `RFD_OFS_FIFO_DATA: rd_mux = rd_word;
      // status packed msb first for a serial shifter
      `RFD_OFS_FIFO_STAT: rd_mux = {24'h0, stat_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      hrdata_ff <= 32'h0000_0000;
      HREADYOUT_O <= 1'b0;
      HRESP_O <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      if (acc_ok && !HWRITE_I)
        hrdata_ff <= rd_mux;
    end
  end
  assign HRDATA_O = hrdata_ff;

  // ==========================================================
  // strobe timing
  // window start and length come from the programmed period
  function automatic logic in_win(input logic [15:0] cnt,
                                  input logic [15:0] per,
                                  input logic [3:0] sh);
    logic [15:0] dly;
    dly = per >> sh;
    in_win = (cnt >= dly) && ({1'b0, cnt} < {1'b0, dly} + {2'b0, per[15:1]});
  endfunction

  logic [15:0] bit_cnt_ff;
  logic [15:0] chip_cnt_ff;
  logic pay_data_ff;
  logic chip_data_ff;
  logic pay_str_ff;
  logic chip_str_ff;

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      bit_cnt_ff <= 16'hffff;
      pay_data_ff <= 1'b0;
    end
    else if (dclk_rise)
    begin
      bit_cnt_ff <= 16'h0000;
      pay_data_ff <= sync2_ff.data;
    end
    else if (bit_cnt_ff != 16'hffff)
      bit_cnt_ff <= bit_cnt_ff + 16'h0001;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      chip_cnt_ff <= 16'hffff;
      chip_data_ff <= 1'b0;
    end
    else if (chip_rise)
    begin
      chip_cnt_ff <= 16'h0000;
      chip_data_ff <= sync2_ff.chip;
    end
    else if (chip_cnt_ff != 16'hffff)
      chip_cnt_ff <= chip_cnt_ff + 16'h0001;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      pay_str_ff <= 1'b0;
      chip_str_ff <= 1'b0;
    end
    else
    begin
      pay_str_ff <= in_win(bit_cnt_ff, bit_per, 4'(`RFD_BIT_DLY_SH));
      chip_str_ff <= in_win(chip_cnt_ff, chip_per,
                            4'(`RFD_CHIP_DLY_SH));
    end
  end

  // ==========================================================
  // output pin routing
  logic [7:0] src;
  always_comb
  begin
    src = 8'h00;
    src[RFD_SEL_HIGH] = 1'b1;
    if (act2_ff)
    begin
      src[RFD_SEL_PAY_DATA] = (mode == RFD_POTP) & pay_data_ff;
      src[RFD_SEL_PAY_STR] = (mode == RFD_POTP) & pay_str_ff;
      src[RFD_SEL_CHIP_DATA] = (mode == RFD_CHIP_DATA_MODE) & chip_data_ff;
      src[RFD_SEL_CHIP_STR] = (mode == RFD_CHIP_DATA_MODE) & chip_str_ff;
      src[RFD_SEL_MF] = (mode == RFD_MATCHED_FILTER_MODE) & sync2_ff.mf;
      src[RFD_SEL_RAW] = (mode == RFD_RAW_SLICER_MODE) & sync2_ff.raw;
    end
  end

  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      always_ff @(posedge CLK_I or negedge RSTN_I)
      begin
        if (!RSTN_I)
          PIN_O[g] <= 1'b0;
        else
          PIN_O[g] <= src[pincfg_ff[3*g +: 3]] ^ pincfg_ff[`RFD_PIN_POL + g];
      end
    end
  endgenerate

  // halting the chain lets the lock hold the first packet
  assign RX_HALT_O = locked_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  chk_inactive_low: assert property (!act2_ff |-> src[7:2] == 6'h00)
    else $error("data source active while receiver idle");
  chk_pay_strobe: assert property ($rose(pay_str_ff) |->
      $past(bit_cnt_ff) == (bit_per >> 4))
    else $error("payload strobe starts at wrong delay");
  chk_chip_strobe: assert property ($rose(chip_str_ff) |->
      $past(chip_cnt_ff) == (chip_per >> 3))
    else $error("chip strobe starts at wrong delay");
  chk_ptr_wrap: assert property (wr_en && !fifo_init && wr_ptr_ff == 8'hff
      |=> wr_ptr_ff == 8'h00)
    else $error("write pointer did not wrap");
  chk_rd_advance: assert property (rd_pop && !fifo_init |=>
      rd_ptr_ff == $past(rd_ptr_ff) + 8'($past(rd_n)))
    else $error("read pointer advanced wrongly");
  chk_lock_blocks: assert property (locked_ff |-> !wr_en)
    else $error("write while locked");
  chk_lock_release: assert property (locked_ff && !lock_en |=> !locked_ff
      && !RX_HALT_O)
    else $error("lock held after enable cleared");
  chk_ovf_clear: assert property (ovf_ff && tsi_ok |=> !ovf_ff
      && cnt_ff <= 9'h001)
    else $error("overflow not cleared at start");
  chk_stop_write: assert property ((eom_rise || sl_rise) && !tsi_ok
      |=> !writing_ff)
    else $error("writing went on after stop");
  chk_status_word: assert property (rd_pop |=> stat_ff[5:0] ==
      $past(rd_n) && stat_ff[7] == $past(ovf_ff))
    else $error("status word does not match transfer");
endmodule
`default_nettype wire

// *** test/rfd_demod_model.sv ***
// demodulator stand-in: start pattern, decoded bits, message end, lines
// assumes the bench calls its tasks; its own 160 ns bit clock, no CLK_I
`timescale 1ns/1ps
`default_nettype none
module rfd_demod_model
(
  output var rfd_pkg::rfd_demod_s demod_o
);
  import rfd_pkg::*;
  // ==========================================
  // events, held 160 ns so the sync flops see them
  task automatic pulse(input int which, input logic sel);
    demod_o.tsi_sel = sel;
    case (which)
      0: demod_o.telegram_start_pattern = 1'b1;
      1: demod_o.end_of_message = 1'b1;
      default: demod_o.sync_loss = 1'b1;
    endcase
    #160;
    demod_o.telegram_start_pattern = 1'b0;
    demod_o.end_of_message = 1'b0;
    demod_o.sync_loss = 1'b0;
    demod_o.tsi_sel = ~sel;
    #160;
  endtask
  // ==========================================
  // decoded payload only, one bit per clock rise
  task automatic bits(input int n, input logic [299:0] v);
    for (int i = 0; i < n; i++)
    begin
      demod_o.data = v[i];
      #80 demod_o.dclk = 1'b1;
      #80 demod_o.dclk = 1'b0;
      // hold is over: show the opposite so a late sample is caught
      demod_o.data = ~v[i];
    end
  endtask
  // transparent lines, chip clock marks the chip
  task automatic lines(input logic v);
    demod_o.chip = v;
    demod_o.mf = v;
    demod_o.raw = v;
    #80 demod_o.chip_clk = 1'b1;
    #80 demod_o.chip_clk = 1'b0;
  endtask
  initial demod_o = '0;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the receive fifo over ahb-lite
// assumes the demodulator model drives DEMOD_I
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rfd_pkg::*;
  typedef struct packed {
    logic we;
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] ex;
  } rfd_row_s;
  logic clk, rstn, hsel, hwrite, hready, hresp, rx_act, run_sl, sp_run;
  logic halt;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] pin;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [31:0] w;
  rfd_demod_s demod;
  int miscompares, compares, cycles, n, k;
  rfd_row_s rows [12] = '{
    '{1'b0, 8'h00, '0, '0}, '{1'b0, 8'h04, '0, 32'h0000_0b1a},
    '{1'b0, 8'h08, '0, 32'h0008_0010}, '{1'b0, 8'h0c, '0, '0},
    '{1'b0, 8'h14, '0, '0}, '{1'b0, 8'h18, '0, '0},
    '{1'b1, 8'h08, 32'h0010_0020, '0}, '{1'b0, 8'h08, '0, 32'h0010_0020},
    '{1'b1, 8'h0c, 32'hffff_ffff, '0}, '{1'b0, 8'h0c, '0, '0},
    '{1'b1, 8'h18, 32'hffff_ffff, '0}, '{1'b1, 8'h08, 32'h0008_0010, '0}};
  rfd_demod_model m (.demod_o(demod));
  rfd_rx_fifo dut_u (.CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .DEMOD_I(demod),
    .RX_ACTIVE_I(rx_act), .RUN_SLAVE_I(run_sl), .SP_TO_RUN_I(sp_run),
    .PIN_O(pin), .RX_HALT_O(halt));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      summarize();
    end
  end
  // ==========================================
  // bus master: address phase, then data phase, each until hready
  task automatic ahb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= we;
    hsize <= 3'b010;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, '0, rdata);
    chk(rdata, exp);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // waits for pin b at level lvl, then counts the cycles it stays there
  task automatic width(input int b, input logic lvl);
    k = 0;
    n = 0;
    while (pin[b] !== lvl && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    while (pin[b] === lvl && n < 100)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    {rstn, hsel, hwrite, rx_act, run_sl, sp_run} = '0;
    {htrans, hsize, haddr, hwdata} = '0;
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
    chk(pin, 4'h0);
    foreach (rows[i])
    begin
      ahb(rows[i].we, rows[i].a, rows[i].wd, rdata);
      if (!rows[i].we)
        chk(rdata, rows[i].ex);
    end
    chk(hresp, 1'b0);
    ahb(1'b1, 8'h04, 32'h0000_1b1a, rdata);
    cyc(6);
    chk(pin, 4'h1);
    ahb(1'b1, 8'h04, 32'h0000_0b1a, rdata);
    // plain packet: 40 bits, two pops, status after each
    w = 32'hc3a5_1e0f;
    ahb(1'b1, 8'h00, '0, rdata);
    m.pulse(0, 1'b0);
    m.bits(40, {8'h96, w});
    cyc(4);
    rdc(8'h0c, 32'h0000_0828);
    rdc(8'h10, w);
    rdc(8'h14, 32'h0000_0020);
    rdc(8'h10, 32'h0000_0096);
    rdc(8'h14, 32'h0000_0008);
    m.pulse(1, 1'b0);
    m.bits(2, 2'b11);
    rdc(8'h0c, '0);
    // extended start pattern bit, then sync loss mid-frame
    ahb(1'b1, 8'h00, 32'h0000_0008, rdata);
    m.pulse(0, 1'b1);
    m.bits(3, 3'b010);
    m.pulse(2, 1'b0);
    m.bits(2, 2'b11);
    cyc(4);
    rdc(8'h0c, 32'h0000_0004);
    rdc(8'h10, 32'h0000_0005);
    // lock at message end, refused frame, released by readout
    ahb(1'b1, 8'h00, 32'h0000_0001, rdata);
    m.pulse(0, 1'b0);
    m.bits(4, 4'ha);
    m.pulse(1, 1'b0);
    chk(halt, 1'b1);
    m.pulse(0, 1'b0);
    m.bits(3, 3'b111);
    cyc(4);
    rdc(8'h0c, 32'h0000_0404);
    rdc(8'h10, 32'h0000_000a);
    cyc(3);
    chk(halt, 1'b0);
    // other releases: lock cleared, slave run, self-polling run
    for (int j = 0; j < 3; j++)
    begin
      ahb(1'b1, 8'h00, 32'h0000_0003, rdata);
      m.pulse(0, 1'b0);
      m.bits(1, 1'b1);
      m.pulse(1, 1'b0);
      @(posedge clk);
      if (j == 0)
        ahb(1'b1, 8'h00, 32'h0000_0002, rdata);
      run_sl <= (j == 1);
      sp_run <= (j == 2);
      @(posedge clk);
      {run_sl, sp_run} <= 2'b00;
      cyc(3);
      chk(halt, 1'b0);
      rdc(8'h10, (j == 0) ? 32'h1 : 32'h0);
    end
    // full depth across the wrap, then overflow and restart
    ahb(1'b1, 8'h00, '0, rdata);
    m.pulse(0, 1'b0);
    m.bits(256, {8{w}});
    cyc(4);
    rdc(8'h0c, 32'h0000_0900);
    // drained before the next 256 bits arrive, so no overrun yet
    repeat (8) rdc(8'h10, w);
    m.bits(256, {8{w}});
    m.bits(1, 1'b0);
    cyc(4);
    rdc(8'h0c, 32'h0000_0b00);
    ahb(1'b0, 8'h10, '0, rdata);
    ahb(1'b0, 8'h14, '0, rdata);
    chk(rdata & 32'h80, 32'h80);
    m.pulse(1, 1'b0);
    m.pulse(0, 1'b0);
    rdc(8'h0c, 32'h0000_0800);
    m.bits(4, 4'h9);
    cyc(4);
    rdc(8'h10, 32'h0000_0009);
    // frame start init drops a half-received frame
    ahb(1'b1, 8'h00, 32'h0000_0004, rdata);
    m.pulse(0, 1'b0);
    m.bits(3, 3'b101);
    m.pulse(0, 1'b0);
    m.bits(2, 2'b10);
    cyc(4);
    rdc(8'h0c, 32'h0000_0802);
    rdc(8'h10, 32'h0000_0002);
    // payload strobe width with the receiver active
    rx_act <= 1'b1;
    ahb(1'b1, 8'h00, 32'h0000_0010, rdata);
    m.pulse(0, 1'b0);
    fork
      m.bits(1, 1'b1);
      width(1, 1'b1);
    join
    chk(n, 8);
    chk(pin[0], 1'b1);
    // transparent modes route their line to pin 0
    for (int j = 0; j < 3; j++)
    begin
      ahb(1'b1, 8'h00, {25'h0, RFD_CHIP_DATA_MODE + 3'(j), 4'h0}, rdata);
      // chip mode also routes the inverted chip strobe to pin 1
      ahb(1'b1, 8'h04, (j == 0) ? {16'h0, 4'h2, 6'h0, RFD_SEL_CHIP_STR,
        RFD_SEL_CHIP_DATA} : {29'h0, (j == 1) ? RFD_SEL_MF : RFD_SEL_RAW},
        rdata);
      cyc(2);
      if (j == 0)
      begin
        fork
          m.lines(1'b1);
          width(1, 1'b0);
        join
        chk(n, 4);
      end
      else
        m.lines(1'b1);
      cyc(6);
      chk(pin[0], 1'b1);
      m.lines(1'b0);
      cyc(6);
      chk(pin[0], 1'b0);
    end
    // reset in mid-run brings outputs and fifo state back
    rstn <= 1'b0;
    cyc(2);
    chk({hready, hresp, halt, pin}, 7'h00);
    rstn <= 1'b1;
    cyc(2);
    rdc(8'h0c, '0);
    summarize();
  end
endmodule
`default_nettype wire
